// ===== hdl/ext_mem_pins.sv
// external memory bus pin controller
`include "emi_params.svh"
module ext_mem_pins
   import emi_pkg::*;
#(
   parameter int STROBE_CYC = `STROBE_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // access request from the core
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_write,
   input  wire logic        req_program,
   input  wire logic [15:0] req_wdata,
   output logic             rsp_valid,
   output logic [15:0]      rsp_rdata,
   // configuration bits
   input  wire logic        bus_drive_hold_bit,
   input  wire logic [15:0] port_f_pullup_reg,
   input  wire logic [15:0] port_d_pullup_reg,
   input  wire logic        system_pullup_disable_ctrl,
   input  wire logic [8:0]  port_f_gpio_sel,
   input  wire logic        port_d_pin_eight_gpio,
   // pins
   input  wire logic [15:0] data_lines_in,
   output logic [15:0]      data_lines_out,
   output logic [15:0]      data_lines_oe,
   output logic [15:0]      data_pullup_en,
   output logic             read_strobe_n,
   output logic             read_strobe_oe,
   output logic             write_strobe_n,
   output logic             write_strobe_oe,
   output logic             strobe_pullup_en,
   output logic             program_select_n,
   output logic             program_select_oe,
   output logic             ps_pullup_en,
   output logic             data_select_n,
   output logic             data_select_oe,
   output logic             ds_pullup_en,
   output logic [8:0]       port_f_gpio_owned
);
   ////////////////////////////////////////////////////////////////////////
   bus_state_e  state_r, state_nxt;
   logic [7:0]  cnt_r;
   logic        wr_r;
   logic        prog_r;
   logic [15:0] wdata_r;
   logic [15:0] rdata_r;
   logic        rsp_r;
   logic [8:0]  f_gpio_r;

   pin_sync_if sync_bus ();

   pin_sync #(
      .W(16)
   ) u_sync (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .pin_in  (data_lines_in),
      .sync    (sync_bus)
   );

   pullup_map u_pu (
      .port_f_pullup_reg          (port_f_pullup_reg),
      .port_d_pullup_reg          (port_d_pullup_reg),
      .system_pullup_disable_ctrl (system_pullup_disable_ctrl),
      .ps_is_gpio                 (port_d_pin_eight_gpio),
      .data_pullup_en             (data_pullup_en),
      .strobe_pullup_en           (strobe_pullup_en),
      .ps_pullup_en               (ps_pullup_en),
      .ds_pullup_en               (ds_pullup_en)
   );

   ////////////////////////////////////////////////////////////////////////
   wire in_read  = (state_r == st_read);
   wire in_write = (state_r == st_write);
   wire active   = in_read || in_write;
   wire cnt_end  = (cnt_r == 8'(STROBE_CYC - 1));
   wire drive_ctl = active || bus_drive_hold_bit; // R9
   wire rd_done   = (state_r == st_done) && !wr_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_idle:  if (req_valid) state_nxt = req_write ? st_write : st_read;
         st_read:  if (cnt_end) state_nxt = st_done;
         st_write: if (cnt_end) state_nxt = st_done;
         st_done:  state_nxt = st_idle;
         default:  state_nxt = st_idle;
      endcase
   end

   assign req_ready = (state_r == st_idle);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= st_idle;
         cnt_r   <= 8'h00;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= (active && !cnt_end) ? cnt_r + 8'h01 : 8'h00;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_r    <= 1'b0;
         prog_r  <= 1'b0;
         wdata_r <= 16'h0000;
      end else if (req_valid && req_ready) begin
         wr_r    <= req_write;
         prog_r  <= req_program;
         wdata_r <= req_wdata;
      end
   end

   // latch one cycle after the strobe rises; two-flop delay means the word sampled under the
   // strobe only reaches the synchroniser output one cycle later
   // limitation: needs a strobe of two cycles or more
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= 16'h0000;
         rsp_r   <= 1'b0;
      end else begin
         rsp_r <= rd_done;
         if (rd_done) begin
            rdata_r <= sync_bus.level; // R5
         end
      end
   end

   assign rsp_valid = rsp_r;
   assign rsp_rdata = rdata_r;

   // strobes come from one-hot states so they cannot overlap
   assign read_strobe_n  = !in_read; // R3 R15
   assign write_strobe_n = !in_write; // R6 R15
   assign read_strobe_oe  = drive_ctl; // R9
   assign write_strobe_oe = drive_ctl; // R9

   // selects qualified by strobes only; memory ignores them otherwise
   assign program_select_n  = !(active && prog_r); // R11 R8
   assign data_select_n     = !(active && !prog_r); // R14
   assign program_select_oe = !port_d_pin_eight_gpio && drive_ctl; // R9
   assign data_select_oe    = drive_ctl;

   // data lines: outputs only in write; inputs during read
   assign data_lines_out = wdata_r; // R6
   assign data_lines_oe  = {16{in_write}}; // R4 R6

   ////////////////////////////////////////////////////////////////////////
   // port f gpio takeover of data 7..15 only after reset, default bus role
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         f_gpio_r <= 9'h000; // R1
      end else begin
         f_gpio_r <= port_f_gpio_sel;
      end
   end

   assign port_f_gpio_owned = f_gpio_r;
endmodule

// ===== common/emi_params.svh
// constants for the external memory pin block
// How it works
// [R1] after reset data pins 7..15 serve the memory bus, not port f
// [R2] clearing a port f pull-up bit kills that pin's pull-up; bit 8 is data 15
// [R3] read strobe is low for the whole external read cycle
// [R4] read strobe low makes all sixteen data lines inputs; memory drives
// [R5] read data captured on the edge where read strobe returns high; the block latches, one cycle later, the word sampled one edge earlier
// [R6] writes drive write strobe low and present data on all sixteen lines
// [R7] external memory latches write data as write strobe rises
// [R8] memory honours address and selects only while a strobe is low
// [R9] bus drive hold bit chooses tri-state or driven strobes while idle
// [R10] software should set the bus drive hold bit to one
// [R11] chip select zero resets as active-low program memory select
// [R12] system pull-up disable control bit kills strobe pin pull-ups
// [R13] port d pull-up bit 8 clear kills program select pin pull-up as gpio
// [R14] chip select one resets as active-low data memory select
// [R15] read and write strobes are never low together
`ifndef EMI_PARAMS_SVH
`define EMI_PARAMS_SVH
`define DATA_W         16
`define PORTF_LO       7
`define PORTF_N        9
`define PORTF_TOP_BIT  8
`define PORTD_PS_BIT   8
`define PORTD_DS_BIT   9
`define STROBE_CYC     2
`define PORTF_PUR_RST  16'hffff
`define PORTD_PUR_RST  16'hffff
`endif

// ===== common/emi_pkg.sv
// types for the external memory pin block
package emi_pkg;
   typedef enum logic [3:0] {
      st_idle  = 4'h1,
      st_read  = 4'h2,
      st_write = 4'h4,
      st_done  = 4'h8
   } bus_state_e;
   typedef logic [15:0] word_t;
endpackage

// ===== common/pin_sync_if.sv
// synchronised data pin levels passed between modules
interface pin_sync_if;
   logic [15:0] level;
   modport src (output level);
   modport dst (input level);
endinterface

// ===== hdl/pin_sync.sv
// two-flop synchroniser for the data pins
module pin_sync
   import emi_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         clk_sys,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] pin_in,
   pin_sync_if.src           sync
);
   logic [W-1:0] meta_r;
   logic [W-1:0] hold_r;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= '0;
         hold_r <= '0;
      end else begin
         meta_r <= pin_in;
         hold_r <= meta_r;
      end
   end

   assign sync.level = hold_r;
endmodule

// ===== hdl/pullup_map.sv
// pull-up enables for data, strobe and select pins
`include "emi_params.svh"
module pullup_map
   import emi_pkg::*;
(
   input  wire logic [15:0] port_f_pullup_reg,
   input  wire logic [15:0] port_d_pullup_reg,
   input  wire logic        system_pullup_disable_ctrl,
   input  wire logic        ps_is_gpio,
   output logic [15:0]      data_pullup_en,
   output logic             strobe_pullup_en,
   output logic             ps_pullup_en,
   output logic             ds_pullup_en
);
   genvar i;
   // data lines 7..15 map to port f bits 0..8; lower lines always pulled
   generate
      for (i = 0; i < `DATA_W; i++) begin : g_pu
         if (i >= `PORTF_LO) begin : g_f
            assign data_pullup_en[i] = port_f_pullup_reg[i-`PORTF_LO]; // R2
         end else begin : g_o
            assign data_pullup_en[i] = 1'b1;
         end
      end
   endgenerate

   assign strobe_pullup_en = !system_pullup_disable_ctrl; // R12
   // in memory-select role the pin has its default pull-up
   assign ps_pullup_en = ps_is_gpio ? port_d_pullup_reg[`PORTD_PS_BIT] : 1'b1; // R13
   assign ds_pullup_en = port_d_pullup_reg[`PORTD_DS_BIT];
endmodule

// ===== bench/emi_monitor.sv
// assertions on the pins of the external memory block
module emi_monitor (
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic        req_write,
   input wire logic        req_program,
   input wire logic        bus_drive_hold_bit,
   input wire logic        read_strobe_n,
   input wire logic        read_strobe_oe,
   input wire logic        write_strobe_n,
   input wire logic [15:0] data_lines_oe,
   input wire logic        program_select_n,
   input wire logic        data_select_n,
   input wire logic        rsp_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire take = req_valid && req_ready;
   property p_apart; !(!read_strobe_n && !write_strobe_n); endproperty
   a_apart: assert property (p_apart) else $error("strobes low together");
   property p_rd; take && !req_write |=> !read_strobe_n [*2] ##1 read_strobe_n; endproperty
   a_rd: assert property (p_rd) else $error("read strobe length");
   property p_rdin; !read_strobe_n |-> data_lines_oe == 16'h0000; endproperty
   a_rdin: assert property (p_rdin) else $error("data driven in read");
   property p_cap; take && !req_write |=> ##3 rsp_valid; endproperty
   a_cap: assert property (p_cap) else $error("no read answer");
   property p_wr; take && req_write |=> (!write_strobe_n && &data_lines_oe) [*2]; endproperty
   a_wr: assert property (p_wr) else $error("write cycle pins");
   property p_ps; take && req_program |=> !program_select_n [*2]; endproperty
   a_ps: assert property (p_ps) else $error("program select missing");
   property p_ds; take && !req_program |=> !data_select_n [*2] ##1 data_select_n; endproperty
   a_ds: assert property (p_ds) else $error("data select wrong");
   property p_idle; req_ready |-> read_strobe_oe == bus_drive_hold_bit; endproperty
   a_idle: assert property (p_idle) else $error("idle strobe drive");
   c_rd: cover property (take && !req_write);
   c_wr: cover property (take && req_write);
   c_prg: cover property (take && req_program && !req_write);
endmodule
bind ext_mem_pins emi_monitor u_mon (.*);

// ===== bench/sram_model.sv
// behavioural static memory on the far side of the pins
module sram_model (
   input  wire logic        clk_sys,
   input  wire logic        read_strobe_n,
   input  wire logic        write_strobe_n,
   input  wire logic        program_select_n,
   input  wire logic        data_select_n,
   input  wire logic [15:0] data_lines_out,
   output logic             drv,
   output logic [15:0]      rdd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [2];
   wire sel = !(program_select_n && data_select_n);
   // last sample under the strobe is the word held at its rise
   always @(posedge clk_sys) begin
      if (!write_strobe_n && sel) mem[program_select_n] <= data_lines_out;
   end
   assign drv = !read_strobe_n && sel;
   assign rdd = mem[program_select_n];
endmodule

// ===== bench/external_memory_bus_pins_bench.sv
// bench for the external memory pin block
module external_memory_bus_pins_bench;
   import emi_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, reset_n, req_valid, req_ready, req_write, req_program, rsp_valid;
   logic bus_drive_hold_bit, system_pullup_disable_ctrl, port_d_pin_eight_gpio, drv;
   logic read_strobe_n, read_strobe_oe, write_strobe_n, write_strobe_oe, strobe_pullup_en;
   logic program_select_n, program_select_oe, ps_pullup_en;
   logic data_select_n, data_select_oe, ds_pullup_en;
   word_t req_wdata, rsp_rdata, data_lines_out, data_lines_oe, data_pullup_en, rdd, q;
   word_t port_f_pullup_reg, port_d_pullup_reg, data_lines_in;
   logic [8:0] port_f_gpio_sel, port_f_gpio_owned;
   int error_cnt = 0;
   int n_tests = 0;
   typedef struct {logic w; logic p; word_t d;} row_s;
   row_s rows[8] = '{'{1,1,16'ha55a}, '{1,0,16'h0ff0}, '{0,1,16'ha55a}, '{0,0,16'h0ff0},
                     '{1,1,16'h0000}, '{0,1,16'h0000}, '{1,0,16'h8001}, '{0,0,16'h8001}};
   // released lines float up to the pull-up level
   assign data_lines_in = |data_lines_oe ? data_lines_out : drv ? rdd : 16'hffff;
   ext_mem_pins dut (.*);
   sram_model mem_i (.*);
   initial begin
      clk_sys = 0;
      forever #50 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////////
   task chk(input string n, input word_t e, input word_t g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task acc(input logic w, input logic p, input word_t d);
      while (req_ready !== 1'b1) @(negedge clk_sys);
      {req_valid, req_write, req_program, req_wdata} = {1'b1, w, p, d};
      @(negedge clk_sys);
      req_valid = 0;
      repeat (4) begin
         if (rsp_valid === 1'b1) q = rsp_rdata;
         @(negedge clk_sys);
      end
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #60000;
      error_cnt++;
      tally_and_finish;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {req_valid, req_write, req_program, bus_drive_hold_bit} = '0;
      {system_pullup_disable_ctrl, port_d_pin_eight_gpio, port_f_gpio_sel, req_wdata} = '0;
      port_f_pullup_reg = 16'hffff;
      port_d_pullup_reg = 16'hffff;
      reset_n = 0;
      repeat (20) @(negedge clk_sys);
      chk("port_f_gpio_owned", 16'h0, {7'h0, port_f_gpio_owned});
      reset_n = 1;
      @(negedge clk_sys);
      chk("read_strobe_oe", 16'h0, {15'h0, read_strobe_oe});
      bus_drive_hold_bit = 1;
      foreach (rows[i]) begin
         q = 'x;
         acc(rows[i].w, rows[i].p, rows[i].d);
         if (!rows[i].w) chk("rsp_rdata", rows[i].d, q);
      end
      for (int k = 0; k < 9; k++) begin
         port_f_pullup_reg = ~(16'h1 << k);
         #1 chk("data_pullup_en", {~(9'h1 << k), 7'h7f}, data_pullup_en);
      end
      system_pullup_disable_ctrl = 1;
      port_d_pin_eight_gpio = 1;
      port_d_pullup_reg = 16'hfcff;
      #1 chk("strobe_pullup_en", 16'h0, {15'h0, strobe_pullup_en});
      chk("ps_pullup_en", 16'h0, {15'h0, ps_pullup_en});
      chk("program_select_oe", 16'h0, {15'h0, program_select_oe});
      chk("ds_pullup_en", 16'h0, {15'h0, ds_pullup_en});
      @(negedge clk_sys);
      port_f_gpio_sel = 9'h1ff;
      repeat (2) @(negedge clk_sys);
      chk("port_f_gpio_owned", 16'h01ff, {7'h0, port_f_gpio_owned});
      // reset in mid-write must drop the strobe and release the lines at once
      {req_valid, req_write, req_wdata} = {1'b1, 1'b1, 16'h1234};
      @(negedge clk_sys);
      {req_valid, reset_n} = 2'b00;
      #1 chk("write_strobe_n", 16'h1, {15'h0, write_strobe_n});
      chk("data_lines_oe", 16'h0, data_lines_oe);
      chk("port_f_gpio_owned", 16'h0, {7'h0, port_f_gpio_owned});
      @(negedge clk_sys);
      reset_n = 1;
      q = 'x;
      acc(1'b0, 1'b0, 16'h0000);
      chk("rsp_rdata", 16'h8001, q);
      tally_and_finish;
   end
endmodule
